// ### rtl/itc_bus_mon.sv
`timescale 1ns/10ps
module itc_bus_mon
  import itc_pkg::*;
(
  input  wire logic     mclk_in,  // system clock
  input  wire logic     srst_in,  // sync reset, high
  input  wire logic     scl_in,   // serial clock pin
  input  wire logic     sda_in,   // serial data pin
  output itc_evt_t      evt_out   // decoded line events
);

  logic [1:0] scl_q;
  logic [1:0] sda_q;
  logic       scl_old_q;
  logic       sda_old_q;

  wire scl_s = scl_q[1];
  wire sda_s = sda_q[1];

  always_ff @(posedge mclk_in)
  begin
    if (srst_in)
    begin
      scl_q     <= 2'h3;
      sda_q     <= 2'h3;
      scl_old_q <= 1'b1;
      sda_old_q <= 1'b1;
    end
    else
    begin
      scl_q     <= {scl_q[0], scl_in};
      sda_q     <= {sda_q[0], sda_in};
      scl_old_q <= scl_s;
      sda_old_q <= sda_s;
    end
  end

  // start/stop: data moves while clock stays high
  assign evt_out.start    = scl_s & scl_old_q & sda_old_q & ~sda_s;
  assign evt_out.stop     = scl_s & scl_old_q & ~sda_old_q & sda_s;
  assign evt_out.scl_rise = scl_s & ~scl_old_q;
  assign evt_out.scl_fall = ~scl_s & scl_old_q;
  assign evt_out.sda      = sda_s;

endmodule

// ### rtl/itc_pkg.sv
package itc_pkg;

  localparam int          ADDR_W        = 8;
  localparam logic [7:0]  REG_CTRL_HIGH = 8'h00;
  localparam logic [7:0]  REG_RX_DATA   = 8'h04;
  localparam logic [7:0]  REG_RX_STAT   = 8'h08;
  localparam logic [7:0]  REG_IRQ_STAT  = 8'h0C;
  localparam logic [7:0]  REG_IRQ_MASK  = 8'h10;
  localparam logic [7:0]  REG_OWN_ADDR  = 8'h14;

  localparam logic [6:0]  CTRL_RESET     = 7'h00;
  localparam logic [6:0]  OWN_ADDR_RESET = 7'h2A;
  localparam logic [3:0]  IRQ_RESET      = 4'h0;
  localparam logic [7:0]  RX_RESET       = 8'h00;

  localparam int          IRQ_START     = 0;
  localparam int          IRQ_STOP      = 1;
  localparam int          IRQ_RX        = 2;
  localparam int          IRQ_OVF       = 3;
  localparam int          RXS_FULL      = 0;
  localparam int          RXS_OVF       = 1;

  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;
  localparam logic [3:0]  BITS_PER_BYTE = 4'h8;

  // control high register, bits 6..0
  typedef struct packed {
    logic stop_irq_enable;
    logic start_irq_enable;
    logic overwrite_enable;
    logic sda_hold_select;
    logic target_collision_detect_enable;
    logic address_hold_enable;
    logic data_hold_enable;
  } itc_ctrl_t;

  // bus events seen by the line monitor
  typedef struct packed {
    logic start;
    logic stop;
    logic scl_rise;
    logic scl_fall;
    logic sda;
  } itc_evt_t;

endpackage

// ### rtl/itc_top.sv
`timescale 1ns/10ps
module itc_top
  import itc_pkg::*;
(
  input  wire logic              mclk_in,          // 50 MHz clock
  input  wire logic              srst_in,          // sync reset, high
  input  wire logic [ADDR_W-1:0] s_axi_awaddr_in,  // write address
  input  wire logic              s_axi_awvalid_in, // write addr valid
  output      logic              s_axi_awready_out,// write addr ready
  input  wire logic [31:0]       s_axi_wdata_in,   // write data
  input  wire logic [3:0]        s_axi_wstrb_in,   // byte strobes
  input  wire logic              s_axi_wvalid_in,  // write data valid
  output      logic              s_axi_wready_out, // write data ready
  output      logic [1:0]        s_axi_bresp_out,  // write response
  output      logic              s_axi_bvalid_out, // write resp valid
  input  wire logic              s_axi_bready_in,  // write resp ready
  input  wire logic [ADDR_W-1:0] s_axi_araddr_in,  // read address
  input  wire logic              s_axi_arvalid_in, // read addr valid
  output      logic              s_axi_arready_out,// read addr ready
  output      logic [31:0]       s_axi_rdata_out,  // read data
  output      logic [1:0]        s_axi_rresp_out,  // read response
  output      logic              s_axi_rvalid_out, // read data valid
  input  wire logic              s_axi_rready_in,  // read data ready
  input  wire logic              scl_in,           // serial clock pin
  input  wire logic              sda_in,           // serial data pin
  output      logic              sda_out,          // data drive level
  output      logic              sda_oe_out,       // data drive enable
  output      logic              irq_out           // interrupt level
);

  typedef enum logic [1:0] {ST_IDLE, ST_SHIFT, ST_ACK, ST_SKIP} itc_st_t;

  itc_evt_t   evt;
  itc_ctrl_t  ctrl_q;
  itc_st_t    st_q;
  logic [6:0] own_q;
  logic [7:0] shift_q;
  logic [3:0] cnt_q;
  logic       first_q;
  logic       ack_q;
  logic [7:0] rx_q;
  logic       full_q;
  logic       ovf_q;
  logic [3:0] irq_stat_q;
  logic [3:0] irq_mask_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic       aw_have_q;
  logic [31:0] wdata_q;
  logic       wstrb0_q;
  logic       w_have_q;
  logic       bvalid_q;
  logic [1:0] bresp_q;
  logic       rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;

  itc_bus_mon u_mon
  (
    .mclk_in (mclk_in),
    .srst_in (srst_in),
    .scl_in  (scl_in),
    .sda_in  (sda_in),
    .evt_out (evt)
  );

  // ---------------- bus slave decode ----------------
  wire do_write = aw_have_q & w_have_q & ~bvalid_q;
  wire do_read  = s_axi_arvalid_in & ~rvalid_q;
  wire wr_ctrl  = do_write & wstrb0_q & (awaddr_q == REG_CTRL_HIGH);
  wire wr_rxs   = do_write & wstrb0_q & (awaddr_q == REG_RX_STAT);
  wire wr_mask  = do_write & wstrb0_q & (awaddr_q == REG_IRQ_MASK);
  wire wr_own   = do_write & wstrb0_q & (awaddr_q == REG_OWN_ADDR);
  wire wr_ok    = (awaddr_q == REG_CTRL_HIGH) | (awaddr_q == REG_RX_STAT) |
                  (awaddr_q == REG_IRQ_MASK) | (awaddr_q == REG_OWN_ADDR);
  wire rd_data  = do_read & (s_axi_araddr_in == REG_RX_DATA);
  wire rd_irq   = do_read & (s_axi_araddr_in == REG_IRQ_STAT);
  wire wr_ok_r  = (s_axi_araddr_in == REG_CTRL_HIGH) |
                  (s_axi_araddr_in == REG_RX_STAT) |
                  (s_axi_araddr_in == REG_IRQ_MASK) |
                  (s_axi_araddr_in == REG_OWN_ADDR);
  wire rd_ok    = wr_ok_r | (s_axi_araddr_in == REG_RX_DATA) |
                  (s_axi_araddr_in == REG_IRQ_STAT);

  // unused upper bits read as zero
  logic [31:0] rd_mux;
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    case (s_axi_araddr_in)
      REG_CTRL_HIGH: rd_mux[6:0] = ctrl_q;
      REG_RX_DATA:   rd_mux[7:0] = rx_q;
      REG_RX_STAT:   rd_mux[1:0] = {ovf_q, full_q};
      REG_IRQ_STAT:  rd_mux[3:0] = irq_stat_q;
      REG_IRQ_MASK:  rd_mux[3:0] = irq_mask_q;
      REG_OWN_ADDR:  rd_mux[6:0] = own_q;
      default:       rd_mux      = 32'h0000_0000;
    endcase
  end

  assign s_axi_awready_out = ~aw_have_q;
  assign s_axi_wready_out  = ~w_have_q;
  assign s_axi_arready_out = ~rvalid_q;
  assign s_axi_bvalid_out  = bvalid_q;
  assign s_axi_bresp_out   = bresp_q;
  assign s_axi_rvalid_out  = rvalid_q;
  assign s_axi_rdata_out   = rdata_q;
  assign s_axi_rresp_out   = rresp_q;

  always_ff @(posedge mclk_in)
  begin
    if (srst_in)
    begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      awaddr_q  <= '0;
      wdata_q   <= 32'h0000_0000;
      wstrb0_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid_in & ~aw_have_q)
      begin
        aw_have_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr_in;
      end
      if (s_axi_wvalid_in & ~w_have_q)
      begin
        w_have_q <= 1'b1;
        wdata_q  <= s_axi_wdata_in;
        wstrb0_q <= s_axi_wstrb_in[0];
      end
      if (do_write)
      begin
        aw_have_q <= 1'b0;
        w_have_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        bresp_q   <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end
      else if (bvalid_q & s_axi_bready_in)
        bvalid_q <= 1'b0;
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (srst_in)
    begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= RESP_OKAY;
    end
    else if (do_read)
    begin
      rvalid_q <= 1'b1;
      rdata_q  <= rd_mux;
      rresp_q  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end
    else if (rvalid_q & s_axi_rready_in)
      rvalid_q <= 1'b0;
  end

  // ---------------- target receive path ----------------
  wire byte_done = (st_q == ST_SHIFT) & (cnt_q == BITS_PER_BYTE) &
                   evt.scl_fall;
  wire addr_hit  = shift_q[7:1] == own_q;
  wire take_byte = byte_done & (~first_q | addr_hit);
  // overwrite on: only a full buffer blocks the load
  wire accept_ow = ~full_q;
  // overwrite off: overflow also blocks the load
  wire accept_no = ~full_q & ~ovf_q;
  wire accept    = ctrl_q.overwrite_enable ? accept_ow : accept_no;
  wire load      = take_byte & accept;
  wire overflow  = take_byte & full_q;

  always_ff @(posedge mclk_in)
  begin
    if (srst_in | evt.stop)
      st_q <= ST_IDLE;
    else if (evt.start)
      st_q <= ST_SHIFT;
    else
    begin
      case (st_q)
        ST_IDLE:  st_q <= ST_IDLE;
        ST_SHIFT: if (byte_done) st_q <= load ? ST_ACK : ST_SKIP;
        ST_ACK:   if (evt.scl_fall)
                    st_q <= (first_q & shift_q[0]) ? ST_SKIP : ST_SHIFT;
        ST_SKIP:  st_q <= ST_SKIP;
        default:  st_q <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (srst_in | evt.start)
    begin
      cnt_q   <= 4'h0;
      shift_q <= RX_RESET;
      first_q <= 1'b1;
    end
    else if (st_q == ST_SHIFT & evt.scl_rise & cnt_q != BITS_PER_BYTE)
    begin
      shift_q <= {shift_q[6:0], evt.sda};
      cnt_q   <= cnt_q + 4'h1;
    end
    else if (st_q == ST_ACK & evt.scl_fall)
    begin
      cnt_q   <= 4'h0;
      first_q <= 1'b0;
    end
  end

  // ack is driven through the ninth clock
  always_ff @(posedge mclk_in)
  begin
    if (srst_in)
      ack_q <= 1'b0;
    else if (load)
      ack_q <= 1'b1;
    else if (evt.scl_fall | evt.stop | evt.start)
      ack_q <= 1'b0;
  end

  assign sda_out    = 1'b0;
  assign sda_oe_out = ack_q;

  // holding register takes the byte on load
  always_ff @(posedge mclk_in)
  begin
    if (srst_in)
    begin
      rx_q   <= RX_RESET;
      full_q <= 1'b0;
      ovf_q  <= 1'b0;
    end
    else
    begin
      if (load)
        rx_q <= shift_q;
      full_q <= load | (full_q & ~rd_data);
      ovf_q  <= overflow | (ovf_q & ~(wr_rxs & wdata_q[RXS_OVF]));
    end
  end

  // ---------------- control and interrupts ----------------
  always_ff @(posedge mclk_in)
  begin
    if (srst_in)
    begin
      ctrl_q     <= CTRL_RESET;
      own_q      <= OWN_ADDR_RESET;
      irq_mask_q <= IRQ_RESET;
    end
    else
    begin
      if (wr_ctrl)
        ctrl_q <= wdata_q[6:0];
      if (wr_own)
        own_q <= wdata_q[6:0];
      if (wr_mask)
        irq_mask_q <= wdata_q[3:0];
    end
  end

  logic [3:0] irq_set;
  always_comb
  begin
    irq_set = 4'h0;
    // start or restart, gated by enable
    irq_set[IRQ_START] = evt.start & ctrl_q.start_irq_enable;
    irq_set[IRQ_STOP]  = evt.stop & ctrl_q.stop_irq_enable;
    irq_set[IRQ_RX]    = load;
    irq_set[IRQ_OVF]   = overflow;
  end

  // set wins over read-clear
  always_ff @(posedge mclk_in)
  begin
    if (srst_in)
      irq_stat_q <= IRQ_RESET;
    else
      irq_stat_q <= irq_set | (irq_stat_q & {4{~rd_irq}});
  end

  assign irq_out = |(irq_stat_q & irq_mask_q);

endmodule

// ### verification/itc_i2c_host.sv
`timescale 1ns/10ps
module itc_i2c_host
  import itc_pkg::*;
(
  input  wire logic mclk_in, // bench clock
  output logic      scl_out, // serial clock
  output logic      sda_out, // data, 1 releases
  input  wire logic sda_in   // wire level
);
  initial
  begin
    scl_out = 1'b1;
    sda_out = 1'b1;
  end
  // n quarters of the 160 ns bit, two clocks each
  task automatic gap(input int n);
    repeat (2 * n) @(posedge mclk_in);
  endtask
  // also serves as restart from clock low
  task automatic start();
    @(posedge mclk_in);
    sda_out <= 1'b1;
    gap(1);
    scl_out <= 1'b1;
    gap(1);
    sda_out <= 1'b0;
    gap(2);
    scl_out <= 1'b0;
    gap(1);
  endtask
  task automatic put(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--)
    begin
      sda_out <= b[i];
      gap(1);
      scl_out <= 1'b1;
      gap(2);
      scl_out <= 1'b0;
      gap(1);
    end
    sda_out <= 1'b1;
    gap(1);
    scl_out <= 1'b1;
    gap(1);
    ack = !sda_in;
    gap(1);
    scl_out <= 1'b0;
    gap(1);
  endtask
  task automatic stop();
    sda_out <= 1'b0;
    gap(1);
    scl_out <= 1'b1;
    gap(1);
    sda_out <= 1'b1;
    gap(2);
  endtask
endmodule

// ### verification/itc_top_bench.sv
`timescale 1ns/10ps
module itc_top_bench
  import itc_pkg::*;
;
  logic mclk_in, srst_in, awv, wv, bready, arv, rready, scl, hsda;
  logic awrdy, wrdy, bv, arrdy, rv, dsda, doe, irq, sda_w, ak;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  int err_total = 0;
  int compares = 0;
  localparam logic [7:0] ADR = {OWN_ADDR_RESET, 1'b0};
  assign sda_w = hsda & (doe ? dsda : 1'b1);
  itc_top itc_top_i (.mclk_in(mclk_in), .srst_in(srst_in),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awv),
    .s_axi_awready_out(awrdy), .s_axi_wdata_in(wdata),
    .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wv),
    .s_axi_wready_out(wrdy), .s_axi_bresp_out(bresp),
    .s_axi_bvalid_out(bv), .s_axi_bready_in(bready),
    .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arv),
    .s_axi_arready_out(arrdy), .s_axi_rdata_out(rdata),
    .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rv),
    .s_axi_rready_in(rready), .scl_in(scl), .sda_in(sda_w),
    .sda_out(dsda), .sda_oe_out(doe), .irq_out(irq));
  itc_i2c_host itc_i2c_host_i (.mclk_in(mclk_in), .scl_out(scl),
    .sda_out(hsda), .sda_in(sda_w));
  task automatic chk(input string n, input logic [31:0] s, e);
    compares++;
    if (s !== e)
    begin
      err_total++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  // writes to read-only registers and any access above 8'h14 are refused
  function automatic logic [31:0] resp(input logic [7:0] a, input logic w);
    return (a > 8'h14 || (w && (a == REG_RX_DATA || a == REG_IRQ_STAT)))
      ? 32'(RESP_SLVERR) : 32'h0;
  endfunction
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    logic [1:0] rs;
    @(posedge mclk_in);
    awaddr <= a;
    wdata <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    tb = 1'b0;
    while (!tb)
    begin
      @(negedge mclk_in);
      ta = awv && awrdy;
      tw = wv && wrdy;
      tb = bv;
      rs = bresp;
      @(posedge mclk_in);
      if (ta) awv <= 1'b0;
      if (tw) wv <= 1'b0;
    end
    bready <= 1'b0;
    chk("bresp", 32'(rs), resp(a, 1'b1));
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic ta, tr;
    logic [31:0] d;
    logic [1:0] rs;
    @(posedge mclk_in);
    araddr <= a;
    arv <= 1'b1;
    rready <= 1'b1;
    tr = 1'b0;
    while (!tr)
    begin
      @(negedge mclk_in);
      ta = arv && arrdy;
      tr = rv;
      d = rdata;
      rs = rresp;
      @(posedge mclk_in);
      if (ta) arv <= 1'b0;
    end
    rready <= 1'b0;
    chk("rdata", d, e);
    chk("rresp", 32'(rs), resp(a, 1'b0));
  endtask
  task automatic irq_chk(input logic e);
    @(negedge mclk_in);
    chk("irq", 32'(irq), 32'(e));
  endtask
  // one frame to our address, optional second byte
  task automatic xfer(input logic two, input logic [1:0] e);
    logic [1:0] k;
    k = 2'b00;
    itc_i2c_host_i.start();
    itc_i2c_host_i.put(ADR, k[1]);
    if (two) itc_i2c_host_i.put(8'h11, k[0]);
    itc_i2c_host_i.stop();
    repeat (4) @(posedge mclk_in);
    chk("ack", 32'(k), 32'(e));
  endtask
  task automatic finish_test();
    if (err_total == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    mclk_in = 1'b0;
    forever #10 mclk_in = ~mclk_in;
  end
  initial
  begin
    #500_000;
    err_total++;
    finish_test();
  end
  initial
  begin
    {srst_in, awv, wv, bready, arv, rready} = 6'b10_0000;
    {awaddr, araddr, wdata} = '0;
    repeat (5) @(posedge mclk_in);
    srst_in <= 1'b0;
    rd(REG_CTRL_HIGH, 32'h0000_0000);
    wr(REG_CTRL_HIGH, 32'hFFFF_FFFF);
    rd(REG_CTRL_HIGH, 32'h0000_007F);
    wr(REG_RX_DATA, 32'h0000_0001);
    rd(8'h20, 32'h0000_0000);
    wr(REG_IRQ_MASK, 32'h0000_000F);
    wr(REG_CTRL_HIGH, 32'h0000_0020);
    xfer(1'b0, 2'b10);
    irq_chk(1'b1);
    rd(REG_IRQ_STAT, 32'h0000_0005);
    irq_chk(1'b0);
    rd(REG_RX_DATA, 32'(ADR));
    itc_i2c_host_i.start();
    itc_i2c_host_i.put(ADR, ak);
    chk("ack", 32'(ak), 32'h0000_0001);
    rd(REG_IRQ_STAT, 32'h0000_0005);
    rd(REG_RX_DATA, 32'(ADR));
    itc_i2c_host_i.start();
    itc_i2c_host_i.put(ADR, ak);
    itc_i2c_host_i.stop();
    chk("ack", 32'(ak), 32'h0000_0001);
    rd(REG_IRQ_STAT, 32'h0000_0005);
    rd(REG_RX_DATA, 32'(ADR));
    wr(REG_CTRL_HIGH, 32'h0000_0040);
    xfer(1'b0, 2'b10);
    rd(REG_IRQ_STAT, 32'h0000_0006);
    rd(REG_RX_DATA, 32'(ADR));
    wr(REG_CTRL_HIGH, 32'h0000_0000);
    xfer(1'b1, 2'b10);
    rd(REG_IRQ_STAT, 32'h0000_000C);
    rd(REG_RX_DATA, 32'(ADR));
    xfer(1'b0, 2'b00);
    rd(REG_RX_STAT, 32'h0000_0002);
    wr(REG_CTRL_HIGH, 32'h0000_0010);
    xfer(1'b0, 2'b10);
    rd(REG_RX_STAT, 32'h0000_0003);
    irq_chk(1'b1);
    wr(REG_IRQ_MASK, 32'h0000_0000);
    irq_chk(1'b0);
    wr(REG_RX_STAT, 32'h0000_0002);
    rd(REG_RX_STAT, 32'h0000_0001);
    xfer(1'b0, 2'b00);
    rd(REG_RX_STAT, 32'h0000_0003);
    finish_test();
  end
endmodule

// ### verification/itc_top_monitor.sv
`timescale 1ns/10ps
module itc_top_monitor
  import itc_pkg::*;
(
  input wire logic        mclk_in,           // clock
  input wire logic        srst_in,           // reset
  input wire logic        s_axi_awvalid_in,  // aw valid
  input wire logic        s_axi_awready_out, // aw ready
  input wire logic        s_axi_wvalid_in,   // w valid
  input wire logic        s_axi_wready_out,  // w ready
  input wire logic        s_axi_bvalid_out,  // b valid
  input wire logic        s_axi_bready_in,   // b ready
  input wire logic [7:0]  s_axi_araddr_in,   // ar addr
  input wire logic        s_axi_arvalid_in,  // ar valid
  input wire logic        s_axi_arready_out, // ar ready
  input wire logic [31:0] s_axi_rdata_out,   // r data
  input wire logic [1:0]  s_axi_rresp_out,   // r resp
  input wire logic        s_axi_rvalid_out,  // r valid
  input wire logic        s_axi_rready_in,   // r ready
  input wire logic        sda_oe_out,        // sda enable
  input wire logic        irq_out            // interrupt
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (srst_in);
  logic [3:0] oe_cnt_q;
  logic       ar_take;
  assign ar_take = s_axi_arvalid_in && s_axi_arready_out;
  // cycles the ack drive has stood
  always_ff @(posedge mclk_in)
    if (srst_in || !sda_oe_out) oe_cnt_q <= 4'h0;
    else if (oe_cnt_q != 4'hF) oe_cnt_q <= oe_cnt_q + 4'h1;
  AST_RST: assert property (
    $fell(srst_in) |-> !irq_out && !sda_oe_out && !s_axi_rvalid_out)
    else $error("outputs not idle after reset");
  AST_UPPER: assert property (
    ar_take && s_axi_araddr_in == REG_CTRL_HIGH |=>
    s_axi_rdata_out[31:7] == 25'h0) else $error("upper bits not zero");
  AST_SLVERR: assert property (ar_take && s_axi_araddr_in > 8'h14 |=>
    s_axi_rresp_out == RESP_SLVERR && s_axi_rdata_out == 32'h0000_0000)
    else $error("unmapped read not refused");
  AST_RLAT: assert property (ar_take |=> s_axi_rvalid_out)
    else $error("read answer late");
  AST_RHOLD: assert property (s_axi_rvalid_out && !s_axi_rready_in |=>
    s_axi_rvalid_out && $stable(s_axi_rdata_out))
    else $error("read answer dropped");
  AST_BLAT: assert property (s_axi_awvalid_in && s_axi_awready_out &&
    s_axi_wvalid_in && s_axi_wready_out |=> ##1 s_axi_bvalid_out)
    else $error("write answer late");
  AST_BHOLD: assert property (s_axi_bvalid_out && !s_axi_bready_in |=>
    s_axi_bvalid_out) else $error("write answer dropped");
  AST_ACKLEN: assert property (oe_cnt_q < 4'hB)
    else $error("ack drive too long");
endmodule
bind itc_top itc_top_monitor itc_top_monitor_i (.mclk_in, .srst_in,
  .s_axi_awvalid_in, .s_axi_awready_out, .s_axi_wvalid_in,
  .s_axi_wready_out, .s_axi_bvalid_out, .s_axi_bready_in,
  .s_axi_araddr_in, .s_axi_arvalid_in, .s_axi_arready_out,
  .s_axi_rdata_out, .s_axi_rresp_out, .s_axi_rvalid_out,
  .s_axi_rready_in, .sda_oe_out, .irq_out);
